// ===== its_cfg.svh
// register map, field positions, reset values and timing counts of the tx request slice
`ifndef ITS_CFG_SVH
`define ITS_CFG_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ITS_FCN0_ADDR      8'had
`define ITS_DOUT_ADDR      8'hae
`define ITS_STAT_ADDR      8'haf

// ----------------------------------------------------------------
// fifo_control_zero fields
// ----------------------------------------------------------------
`define ITS_IRQ_EN_BIT     7
`define ITS_FLUSH_BIT      6
`define ITS_TH_MSB         5
`define ITS_TH_LSB         4

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define ITS_STAT_REQ_BIT   7
`define ITS_STAT_FULL_BIT  6
`define ITS_STAT_EMPTY_BIT 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ITS_FCN0_RST       8'h00
`define ITS_TH_RST         2'h0
`define ITS_DATA_RST       8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ITS_FLUSH_CYCLES   1

`endif

// ===== its_fifo_if.sv
// carrier between the tx request control and its byte store
`timescale 1ns/10ps

interface its_fifo_if #(
    parameter int DEPTH = 4,
    parameter int CW    = $clog2(DEPTH + 1)
);
    logic              ce;
    logic              flush;
    logic              push;
    its_pkg::its_byte_t push_data;
    logic              pop;
    its_pkg::its_byte_t head_data;
    logic [CW-1:0]     count;
    logic              full;
    logic              empty;

    modport ctrl (
        output ce,
        output flush,
        output push,
        output push_data,
        output pop,
        input  head_data,
        input  count,
        input  full,
        input  empty
    );

    modport store (
        input  ce,
        input  flush,
        input  push,
        input  push_data,
        input  pop,
        output head_data,
        output count,
        output full,
        output empty
    );
endinterface // its_fifo_if

// ===== its_fifo_store.sv
// flip-flop byte store with counters for the tx queue
`timescale 1ns/10ps
`include "its_cfg.svh"

module its_fifo_store #(
    parameter int DEPTH = 4,
    parameter int CW    = $clog2(DEPTH + 1),
    parameter int PW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    input wire logic   mclk,
    input wire logic   rstn,
    its_fifo_if.store  f
);
    its_pkg::its_byte_t mem_q [DEPTH];
    logic [PW-1:0]      wr_ptr_q;
    logic [PW-1:0]      rd_ptr_q;
    logic [CW-1:0]      count_q;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire logic          push_ok;
    wire logic          pop_ok;
    wire logic [PW-1:0] wr_ptr_inc;
    wire logic [PW-1:0] rd_ptr_inc;
    wire logic [CW-1:0] count_d;

    // flush beats both sides in its cycle; a full push is dropped
    assign push_ok    = f.push && !f.full && !f.flush;
    assign pop_ok     = f.pop && !f.empty && !f.flush;
    assign wr_ptr_inc = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_q + 1'b1);
    assign rd_ptr_inc = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_q + 1'b1);
    assign count_d    = f.flush ? '0 :
                        (push_ok && !pop_ok) ? CW'(count_q + 1'b1) :
                        (!push_ok && pop_ok) ? CW'(count_q - 1'b1) : count_q;

    assign f.head_data = mem_q[rd_ptr_q];
    assign f.count     = count_q;
    assign f.full      = (count_q == CW'(DEPTH));
    assign f.empty     = (count_q == '0);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                mem_q[g] <= `ITS_DATA_RST;
            end else if (f.ce && push_ok && wr_ptr_q == PW'(g)) begin
                mem_q[g] <= f.push_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (f.ce) begin
            // (RULE_02) flush clears counters
            if (f.flush) begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
            end else begin
                if (push_ok) begin
                    wr_ptr_q <= wr_ptr_inc;
                end
                if (pop_ok) begin
                    rd_ptr_q <= rd_ptr_inc;
                end
            end
            count_q <= count_d;
        end
    end
endmodule // its_fifo_store

// ===== its_i2c_reader.sv
// behavioural i2c master side that pulls bytes out of the tx queue
`timescale 1ns/10ps

module its_i2c_reader (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       pull,
    input  wire logic       slow,
    output logic            tx_take,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_byte_valid
);
    its_pkg::its_byte_t got[$];

    // a slow master asks only every other cycle, like a long bus byte
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tx_take <= 1'b0;
        end else begin
            tx_take <= pull && !(slow && tx_take);
        end
    end

    always @(posedge mclk) begin
        if (rstn && tx_byte_valid) begin
            got.push_back(tx_byte);
        end
    end
endmodule // its_i2c_reader

// ===== its_pkg.sv
// types shared by the tx request slice
package its_pkg;

    typedef logic [1:0] its_thresh_t;
    typedef logic [7:0] its_byte_t;

endpackage

// ===== its_tx_request.sv
// tx queue request control: threshold flag, interrupt gate, self-clearing flush
// Function
// (RULE_01) enable bit gates request flag onto interrupt
// (RULE_02) flush write resets counters, drops bytes
// (RULE_03) flush bit self-clears after one cycle
// (RULE_04) flag high when fill <= threshold
// (RULE_05) threshold zero: flag only when empty
// (RULE_06) threshold one: flag at one or none
// (RULE_07) firmware loads bytes through data port
// (RULE_08) flag drops once fill exceeds threshold
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "its_cfg.svh"

module its_tx_request #(
    parameter int DEPTH = 4,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        tx_take,
    output logic      [7:0]  tx_byte,
    output logic             tx_byte_valid,
    output logic             tx_request_flag,
    output logic             slave_irq
);
    its_fifo_if #(.DEPTH(DEPTH), .CW(CW)) fif ();

    its_fifo_store #(.DEPTH(DEPTH), .CW(CW)) u_store (
        .mclk (mclk),
        .rstn (rstn),
        .f    (fif.store)
    );

    logic                tx_request_irq_enable_q;
    logic                tx_queue_flush_q;
    its_pkg::its_thresh_t tx_level_threshold_q;
    logic                tx_request_flag_q;
    logic                slave_irq_q;
    logic [7:0]          reg_rdata_q;
    logic [7:0]          tx_byte_q;
    logic                tx_byte_valid_q;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire logic       hit_fcn0;
    wire logic       hit_dout;
    wire logic       hit_stat;
    wire logic       wr_fcn0;
    wire logic       flush_req;
    wire logic       level_ok;
    wire logic [7:0] fcn0_view;
    wire logic [7:0] stat_view;
    wire logic [7:0] rd_sel;

    assign hit_fcn0  = (reg_addr == `ITS_FCN0_ADDR);
    assign hit_dout  = (reg_addr == `ITS_DOUT_ADDR);
    assign hit_stat  = (reg_addr == `ITS_STAT_ADDR);
    assign wr_fcn0   = reg_wr && hit_fcn0;
    assign flush_req = wr_fcn0 && reg_wdata[`ITS_FLUSH_BIT];

    // (RULE_04) occupancy against threshold
    // (RULE_05) zero means empty only
    // (RULE_06) one means one or none
    assign level_ok  = (fif.count <= CW'(tx_level_threshold_q));

    // receive-side bits of this register live elsewhere and read as zero here
    assign fcn0_view = {tx_request_irq_enable_q, tx_queue_flush_q, tx_level_threshold_q, 4'h0};
    assign stat_view = {tx_request_flag_q, fif.full, fif.empty, 5'(fif.count)};
    assign rd_sel    = hit_fcn0 ? fcn0_view :
                       hit_stat ? stat_view : 8'h00;

    // ----------------------------------------------------------------
    // store hookup
    // ----------------------------------------------------------------
    assign fif.ce        = clk_en;
    // (RULE_02) flush drives counter reset
    assign fif.flush     = tx_queue_flush_q;
    // (RULE_07) data port writes queue a byte
    assign fif.push      = reg_wr && hit_dout;
    assign fif.push_data = reg_wdata;
    assign fif.pop       = tx_take;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tx_request_irq_enable_q <= 1'(`ITS_FCN0_RST >> `ITS_IRQ_EN_BIT);
            tx_level_threshold_q    <= `ITS_TH_RST;
        end else if (clk_en && wr_fcn0) begin
            tx_request_irq_enable_q <= reg_wdata[`ITS_IRQ_EN_BIT];
            tx_level_threshold_q    <= reg_wdata[`ITS_TH_MSB:`ITS_TH_LSB];
        end
    end

    // (RULE_03) flush bit self-clears
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tx_queue_flush_q <= 1'b0;
        end else if (clk_en) begin
            tx_queue_flush_q <= flush_req;
        end
    end

    // ----------------------------------------------------------------
    // request flag and interrupt
    // ----------------------------------------------------------------
    // flag follows the level each enabled cycle, so it never latches high
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tx_request_flag_q <= 1'b0;
            slave_irq_q       <= 1'b0;
        end else if (clk_en) begin
            // (RULE_08) level tracking flag
            tx_request_flag_q <= level_ok;
            // (RULE_01) enable gates interrupt
            slave_irq_q       <= tx_request_irq_enable_q && tx_request_flag_q;
        end
    end

    // ----------------------------------------------------------------
    // register read and byte drain
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata_q <= 8'h00;
        end else if (clk_en) begin
            reg_rdata_q <= reg_rd ? rd_sel : 8'h00;
        end
    end

    // a take on an empty queue or in a flush cycle returns nothing
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tx_byte_q       <= `ITS_DATA_RST;
            tx_byte_valid_q <= 1'b0;
        end else if (clk_en) begin
            tx_byte_valid_q <= tx_take && !fif.empty && !tx_queue_flush_q;
            if (tx_take && !fif.empty && !tx_queue_flush_q) begin
                tx_byte_q <= fif.head_data;
            end
        end
    end

    assign reg_rdata       = reg_rdata_q;
    assign tx_byte         = tx_byte_q;
    assign tx_byte_valid   = tx_byte_valid_q;
    assign tx_request_flag = tx_request_flag_q;
    assign slave_irq       = slave_irq_q;
endmodule // its_tx_request

// ===== its_tx_request_properties.sv
// concurrent checks of the tx request slice at its top ports
`timescale 1ns/10ps
`include "its_cfg.svh"

module its_tx_request_properties #(
    parameter int DEPTH = 4,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       tx_take,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_byte_valid,
    input wire logic       tx_request_flag,
    input wire logic       slave_irq
);
    logic          en_q, fl_q;
    logic [1:0]    th_q;
    logic [CW-1:0] cnt_q;
    wire logic     cfg_wr = clk_en && reg_wr && reg_addr == `ITS_FCN0_ADDR;
    wire logic     push   = clk_en && reg_wr && reg_addr == `ITS_DOUT_ADDR && cnt_q < DEPTH;
    wire logic     pop    = clk_en && tx_take && cnt_q != '0;
    wire logic     le_th  = cnt_q <= CW'(th_q);
    wire logic     le_one = cnt_q <= CW'(2'h1);
    wire logic     empty0 = cnt_q == '0;
    wire logic     gate   = en_q && tx_request_flag;
    wire logic     st_rd  = clk_en && reg_rd && reg_addr == `ITS_STAT_ADDR;
    wire logic     cf_rd  = clk_en && reg_rd && reg_addr == `ITS_FCN0_ADDR;

    // shadow fill level rebuilt from port traffic only, so no internal probe is needed
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            {en_q, fl_q, th_q, cnt_q} <= '0;
        end else if (clk_en) begin
            fl_q  <= cfg_wr && reg_wdata[6];
            cnt_q <= fl_q ? '0 : cnt_q + CW'(push) - CW'(pop);
            if (cfg_wr) begin
                {en_q, th_q} <= {reg_wdata[7], reg_wdata[5:4]};
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_flush;
        cfg_wr && reg_wdata[6];
    endsequence

    a_flag_tracks_fill: assert property ($past(rstn) && $past(clk_en) |->
        tx_request_flag == $past(le_th)) else $error("flag does not follow fill level");
    a_flag_zero_th: assert property ($past(rstn) && $past(clk_en) && $past(th_q) == 2'h0
        |-> tx_request_flag == $past(empty0)) else $error("flag wrong at threshold zero");
    a_flag_one_th: assert property ($past(rstn) && $past(clk_en) && $past(th_q) == 2'h1
        |-> tx_request_flag == $past(le_one)) else $error("flag wrong at threshold one");
    a_flag_drops_above: assert property ($past(rstn) && $past(clk_en) && !$past(le_th)
        |-> !tx_request_flag) else $error("flag held above threshold");
    a_irq_gated: assert property ($past(rstn) && $past(clk_en) |->
        slave_irq == $past(gate)) else $error("interrupt not gated by enable");
    a_flush_drops_bytes: assert property (s_flush ##1 clk_en [*2] |->
        !tx_byte_valid ##1 !tx_byte_valid) else $error("byte delivered after flush");
    a_status_count: assert property (st_rd |=>
        reg_rdata[4:0] == 5'($past(cnt_q))) else $error("status count wrong");
    a_flush_self_clears: assert property (s_flush ##1 clk_en ##1 cf_rd |=>
        !reg_rdata[6]) else $error("flush bit did not clear");
endmodule // its_tx_request_properties

bind its_tx_request its_tx_request_properties #(.DEPTH(DEPTH), .CW(CW)) i_props (
    .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_take(tx_take), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .tx_request_flag(tx_request_flag), .slave_irq(slave_irq));

// ===== its_tx_request_test.sv
// self-checking bench for the tx request slice
`timescale 1ns/10ps
`include "its_cfg.svh"

module its_tx_request_test;
    localparam int DEPTH = 4;
    logic       mclk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
    logic       reg_wr = 1'b0, reg_rd = 1'b0, pull = 1'b0, slow = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
    logic [7:0] reg_rdata, tx_byte;
    logic       tx_take, tx_byte_valid, tx_request_flag, slave_irq;
    int         bad_count = 0, compares = 0;

    always #2 mclk = ~mclk;

    its_tx_request #(.DEPTH(DEPTH)) i_dut (
        .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_take(tx_take), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
        .tx_request_flag(tx_request_flag), .slave_irq(slave_irq));
    its_i2c_reader i_mst (.mclk(mclk), .rstn(rstn), .pull(pull), .slow(slow),
        .tx_take(tx_take), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // flag lags the fill by one cycle and the interrupt by one more
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic drain(input int n, input logic s);
        @(posedge mclk);
        slow <= s;
        pull <= 1'b1;
        repeat (n) @(posedge mclk);
        pull <= 1'b0;
        settle();
    endtask

    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic t_reset();
        rd(`ITS_FCN0_ADDR);
        chk(d, `ITS_FCN0_RST);
        chk(tx_request_flag, 8'h01);
        chk(slave_irq, 8'h00);
        rd(8'h10);
        chk(d, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_thresh();
        for (int th = 0; th < 4; th++) begin
            wr(`ITS_FCN0_ADDR, 8'h40 | 8'(th << 4));
            settle();
            for (int k = 0; k <= DEPTH; k++) begin
                chk(tx_request_flag, 8'(k <= th));
                if (k < DEPTH) wr(`ITS_DOUT_ADDR, 8'(k));
                settle();
            end
        end
        wr(`ITS_DOUT_ADDR, 8'hee);
        rd(`ITS_STAT_ADDR);
        chk(d, 8'h40 | 8'(DEPTH));
        $display("test threshold done");
    endtask

    task automatic t_flush();
        drain(2, 1'b0);
        chk(8'(i_mst.got.size()), 8'h02);
        chk(i_mst.got[1], 8'h01);
        wr(`ITS_FCN0_ADDR, 8'h70);
        rd(`ITS_FCN0_ADDR);
        chk(d, 8'h30);
        rd(`ITS_STAT_ADDR);
        chk(d, 8'ha0);
        drain(2, 1'b0);
        chk(8'(i_mst.got.size()), 8'h02);
        wr(`ITS_DOUT_ADDR, 8'h5a);
        wr(`ITS_DOUT_ADDR, 8'ha5);
        drain(4, 1'b1);
        chk(i_mst.got[2], 8'h5a);
        chk(i_mst.got[3], 8'ha5);
        $display("test flush done");
    endtask

    task automatic t_irq();
        wr(`ITS_FCN0_ADDR, 8'hc0);
        settle();
        chk(slave_irq, 8'h01);
        wr(`ITS_DOUT_ADDR, 8'h33);
        settle();
        chk(slave_irq, 8'h00);
        wr(`ITS_FCN0_ADDR, 8'h40);
        settle();
        chk(tx_request_flag, 8'h01);
        chk(slave_irq, 8'h00);
        // a data write while the enable is low must not reach the queue
        @(posedge mclk);
        clk_en <= 1'b0;
        wr(`ITS_DOUT_ADDR, 8'h77);
        @(posedge mclk);
        clk_en <= 1'b1;
        settle();
        chk(tx_request_flag, 8'h01);
        rd(`ITS_STAT_ADDR);
        chk(d, 8'ha0);
        $display("test irq done");
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_thresh();
        t_flush();
        t_irq();
        give_verdict();
    end

    initial begin
        #40000;
        bad_count++;
        give_verdict();
    end
endmodule // its_tx_request_test
